// ===== hdl/ctp_timer_pwm.v
// cascaded 16-bit timer unit: 12-bit dithered pwm and 16-bit ppg output
// assumes config and register write ports come from logic on clk
`timescale 1ns/100ps
`include "ctp_consts.vh"
module ctp_timer_pwm #(
  parameter PRESCALE_WIDTH = 11
)(
  input wire clk,
  input wire sys_rst,
  input wire cascade_select,
  input wire high_timer_run,
  input wire [1:0] operating_mode_field,
  input wire output_initial_level,
  input wire double_buffer_enable,
  input wire external_clock_select,
  input wire [2:0] clock_divider_field,
  input wire slow_prescale_select,
  input wire low_frequency_tick,
  input wire external_count_input,
  input wire reg_write,
  input wire [1:0] reg_select,
  input wire [7:0] reg_write_data,
  output wire [15:0] duty_read_value,
  output wire [15:0] period_read_value,
  output wire [15:0] count_value,
  output wire running,
  output wire dithered_output_pin,
  output wire pulse_output_pin,
  output reg low_timer_interrupt,
  output reg high_timer_interrupt
);

// configuration held while the timer runs
reg [1:0] mode;
reg init_level;
reg dbuf_on;
reg ext_sel;
reg [2:0] div_sel;
reg slow_sel;

// staged period bytes and duty low byte, buffers and active compare values
reg [7:0] stage_period_lo;
reg [7:0] stage_period_hi;
reg [7:0] stage_duty_lo;
reg [15:0] buf_duty;
reg [15:0] buf_period;
reg [15:0] active_duty_value;
reg [15:0] active_period_value;

// counting state
reg [15:0] counter;
reg [3:0] frame;
reg duty_hit;
reg out_level;
reg run_q;

wire source_tick;
wire extra_pulse;
wire mode_ok;
wire run_req;
wire is_pwm;
wire is_ppg;
wire commit;
wire [15:0] commit_duty;
wire [15:0] commit_period;
wire [8:0] pwm_match_point;
wire pwm_match;
wire pwm_wrap;
wire frame_end;
wire ppg_duty_match;
wire ppg_period_match;

// the unit only runs cascaded in one of the two supported modes
assign mode_ok = cascade_select
  & ((operating_mode_field == `CTP_MODE_PWM12) | (operating_mode_field == `CTP_MODE_PPG16));
assign run_req = high_timer_run & mode_ok;
assign running = run_q;
assign is_pwm = (mode == `CTP_MODE_PWM12);
assign is_ppg = (mode == `CTP_MODE_PPG16);

// source tick generation
ctp_clock_source #(
  .PRESCALE_WIDTH(PRESCALE_WIDTH)
) u_clock_source (
  .clk(clk),
  .sys_rst(sys_rst),
  .external_clock_select(ext_sel),
  .clock_divider_field(div_sel),
  .slow_prescale_select(slow_sel),
  .low_frequency_tick(low_frequency_tick),
  .external_count_input(external_count_input),
  .source_tick(source_tick)
);

// additional pulse decode for the current frame period
ctp_dither u_dither (
  .frame_index(frame),
  .additional_pulse_field(active_duty_value[3:0]),
  .extra_pulse(extra_pulse)
);

// mode settings are latched only while stopped
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    mode <= 2'b00;
    init_level <= 1'b0;
    dbuf_on <= 1'b0;
    ext_sel <= 1'b0;
    div_sel <= 3'b000;
    slow_sel <= 1'b0;
  end
  else if (!run_q)
  begin
    mode <= operating_mode_field;
    init_level <= output_initial_level;
    dbuf_on <= double_buffer_enable;
    ext_sel <= external_clock_select;
    div_sel <= clock_divider_field;
    slow_sel <= slow_prescale_select;
  end
end

// duty high write commits all four bytes as one value
assign commit = reg_write & (reg_select == `CTP_SEL_DUTY_HI);
assign commit_duty = {reg_write_data, stage_duty_lo};
assign commit_period = {stage_period_hi, stage_period_lo};

// staging of the bytes written ahead of the commit
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    stage_period_lo <= `CTP_REG_RESET;
    stage_period_hi <= `CTP_REG_RESET;
    stage_duty_lo <= `CTP_REG_RESET;
  end
  else if (reg_write)
  begin
    if (reg_select == `CTP_SEL_PERIOD_LO)
      stage_period_lo <= reg_write_data;
    else if (reg_select == `CTP_SEL_PERIOD_HI)
      stage_period_hi <= reg_write_data;
    else if (reg_select == `CTP_SEL_DUTY_LO)
      stage_duty_lo <= reg_write_data;
  end
end

// match points of both modes
assign pwm_match_point = {1'b0, active_duty_value[11:4]} + {8'h00, extra_pulse};
assign pwm_match = run_q & is_pwm & ({1'b0, counter[7:0]} == pwm_match_point);
assign pwm_wrap = run_q & is_pwm & source_tick & (counter[7:0] == `CTP_PWM_LAST);
assign frame_end = pwm_wrap & (frame == `CTP_DITHER_LAST);
assign ppg_duty_match = run_q & is_ppg & (counter == active_duty_value);
assign ppg_period_match = run_q & is_ppg & (counter == active_period_value);

// buffer always keeps the last written value for reads
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    buf_duty <= {`CTP_REG_RESET, `CTP_REG_RESET};
    buf_period <= {`CTP_REG_RESET, `CTP_REG_RESET};
  end
  else if (commit)
  begin
    buf_duty <= commit_duty;
    buf_period <= commit_period;
  end
end

// active compare values: direct write, or reload at frame or period end
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    active_duty_value <= {`CTP_REG_RESET, `CTP_REG_RESET};
    active_period_value <= {`CTP_REG_RESET, `CTP_REG_RESET};
  end
  else if (commit && (!run_q || !dbuf_on))
  begin
    active_duty_value <= commit_duty;
    active_period_value <= commit_period;
  end
  else if (dbuf_on && (frame_end || ppg_period_match))
  begin
    active_duty_value <= buf_duty;
    active_period_value <= buf_period;
  end
end

// reads return the buffered value, not the one in effect
assign duty_read_value = buf_duty;
assign period_read_value = buf_period;
assign count_value = counter;

// counter, frame index and output level
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    run_q <= 1'b0;
    counter <= 16'h0000;
    frame <= 4'h0;
    duty_hit <= 1'b0;
    out_level <= 1'b0;
  end
  else if (!run_req)
  begin
    // stopped: counter cleared, pin at its initial level
    run_q <= 1'b0;
    counter <= 16'h0000;
    frame <= 4'h0;
    duty_hit <= 1'b0;
    out_level <= output_initial_level;
  end
  else if (!run_q)
  begin
    run_q <= 1'b1;
    out_level <= init_level;
  end
  else if (is_ppg)
  begin
    if (ppg_period_match)
    begin
      // a tick landing in the clear cycle still counts, keeping the period whole ticks
      counter <= {15'h0000, source_tick};
      duty_hit <= 1'b0;
      out_level <= init_level;
    end
    else
    begin
      if (source_tick)
        counter <= counter + 16'h0001;
      if (ppg_duty_match && !duty_hit)
      begin
        duty_hit <= 1'b1;
        out_level <= ~init_level;
      end
    end
  end
  else
  begin
    if (pwm_wrap)
    begin
      counter <= 16'h0000;
      frame <= frame + 4'h1;
      duty_hit <= 1'b0;
      out_level <= init_level;
    end
    else
    begin
      if (source_tick)
        counter <= counter + 16'h0001;
      if (pwm_match && !duty_hit)
      begin
        duty_hit <= 1'b1;
        out_level <= ~init_level;
      end
    end
  end
end

// interrupt pulses, one cycle each
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    low_timer_interrupt <= 1'b0;
    high_timer_interrupt <= 1'b0;
  end
  else
  begin
    low_timer_interrupt <= pwm_wrap
      | (ppg_duty_match & ~duty_hit & ~ppg_period_match);
    high_timer_interrupt <= frame_end | ppg_period_match;
  end
end

// each pin shows the waveform in its own mode, else the initial level
assign dithered_output_pin = (run_q && is_pwm) ? out_level : init_level;
assign pulse_output_pin = (run_q && is_ppg) ? out_level : init_level;

endmodule // ctp_timer_pwm

// ===== hdl/ctp_consts.vh
// constants for the cascaded timer pwm / ppg unit
// included by the design files of this block only
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH

// operating mode field codes
`define CTP_MODE_PWM12 2'b10
`define CTP_MODE_PPG16 2'b11

// write select codes for the four timer registers
`define CTP_SEL_PERIOD_LO 2'b00
`define CTP_SEL_PERIOD_HI 2'b01
`define CTP_SEL_DUTY_LO 2'b10
`define CTP_SEL_DUTY_HI 2'b11

// reset value of every timer register byte
`define CTP_REG_RESET 8'hFF

// pwm counter wrap and dither frame
`define CTP_PWM_LAST 8'hFF
`define CTP_DITHER_LAST 4'hF

// clock divider field codes with special meaning
`define CTP_DIV_SLOW4 3'b000
`define CTP_DIV_SLOW3 3'b001
`define CTP_DIV_FULL 3'b111

`endif

// ===== hdl/ctp_clock_source.v
// source clock tick generator for the cascaded timer
// assumes low_frequency_tick is a one-cycle pulse on clk; external input is a raw pin
`timescale 1ns/100ps
`include "ctp_consts.vh"
module ctp_clock_source #(
  parameter PRESCALE_WIDTH = 11
)(
  input wire clk,
  input wire sys_rst,
  input wire external_clock_select,
  input wire [2:0] clock_divider_field,
  input wire slow_prescale_select,
  input wire low_frequency_tick,
  input wire external_count_input,
  output reg source_tick
);

reg [PRESCALE_WIDTH-1:0] prescale;
reg [3:0] slow_prescale;
reg ext_sync1;
reg ext_sync2;
reg ext_last;
reg next_tick;

// free running prescalers for gear and low-frequency clocks
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    prescale <= {PRESCALE_WIDTH{1'b0}};
    slow_prescale <= 4'h0;
  end
  else
  begin
    prescale <= prescale + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
    if (low_frequency_tick)
      slow_prescale <= slow_prescale + 4'h1;
  end
end

// two-stage sync then rising edge detect of the count input
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    ext_sync1 <= 1'b0;
    ext_sync2 <= 1'b0;
    ext_last <= 1'b0;
  end
  else
  begin
    ext_sync1 <= external_count_input;
    ext_sync2 <= ext_sync1;
    ext_last <= ext_sync2;
  end
end

// divider selection, a divided tick fires when the low bits are all ones, an external one on a count input rising edge
always @*
begin
  next_tick = 1'b0;
  if (external_clock_select)
    next_tick = ext_sync2 & ~ext_last;
  else if (slow_prescale_select && clock_divider_field == `CTP_DIV_SLOW4)
    next_tick = low_frequency_tick & (&slow_prescale[3:0]);
  else if (slow_prescale_select && clock_divider_field == `CTP_DIV_SLOW3)
    next_tick = low_frequency_tick & (&slow_prescale[2:0]);
  else
    case (clock_divider_field)
      3'b000: next_tick = &prescale[10:0];
      3'b001: next_tick = &prescale[9:0];
      3'b010: next_tick = &prescale[7:0];
      3'b011: next_tick = &prescale[5:0];
      3'b100: next_tick = &prescale[3:0];
      3'b101: next_tick = &prescale[1:0];
      3'b110: next_tick = prescale[0];
      default: next_tick = 1'b1;
    endcase
end

// registered tick
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
    source_tick <= 1'b0;
  else
    source_tick <= next_tick;
end

endmodule // ctp_clock_source

// ===== hdl/ctp_dither.v
// additional pulse selector for the 12-bit pwm mode
// assumes frame_index counts pwm periods 0..15, period n+1 of the frame
`timescale 1ns/100ps
module ctp_dither (
  input wire [3:0] frame_index,
  input wire [3:0] additional_pulse_field,
  output wire extra_pulse
);

// bit0 period 9, bit1 5/13, bit2 3/7/11/15, bit3 the even periods
assign extra_pulse = (additional_pulse_field[0] & (frame_index == 4'h8))
  | (additional_pulse_field[1] & (frame_index[2:0] == 3'b100))
  | (additional_pulse_field[2] & (frame_index[1:0] == 2'b10))
  | (additional_pulse_field[3] & frame_index[0]);

endmodule // ctp_dither

// ===== tb/ctp_props.sv
// checker for the cascaded timer unit, sees the top ports only
// assumes one clock domain with an active high async reset
`timescale 1ns/100ps
module ctp_props (
  input wire clk,
  input wire sys_rst,
  input wire cascade_select,
  input wire high_timer_run,
  input wire [1:0] operating_mode_field,
  input wire output_initial_level,
  input wire [15:0] count_value,
  input wire running,
  input wire dithered_output_pin,
  input wire pulse_output_pin,
  input wire low_timer_interrupt,
  input wire high_timer_interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // stop request, then a stopped and cleared unit
  sequence s_stop_req;
    running && !high_timer_run;
  endsequence
  sequence s_idle;
    !running && count_value == 16'h0000;
  endsequence
  property p_start;
    !running && high_timer_run && cascade_select && operating_mode_field[1] |=> running;
  endproperty
  property p_nocas;
    !cascade_select |=> !running;
  endproperty
  property p_stop;
    s_stop_req |=> s_idle;
  endproperty
  // stopped pins show the initial level latched on the previous edge
  property p_idle;
    !running && !$past(running) |-> pulse_output_pin == $past(output_initial_level)
      && dithered_output_pin == $past(output_initial_level);
  endproperty
  property p_ppg_duty;
    running && operating_mode_field == 2'b11 && low_timer_interrupt |-> pulse_output_pin != output_initial_level;
  endproperty
  property p_ppg_per;
    running && operating_mode_field == 2'b11 && high_timer_interrupt
      |-> pulse_output_pin == output_initial_level && count_value < 16'h0002;
  endproperty
  property p_pwm_ovf;
    running && operating_mode_field == 2'b10 && low_timer_interrupt
      |-> dithered_output_pin == output_initial_level && count_value[7:0] < 8'h02;
  endproperty
  property p_pwm_frame;
    running && operating_mode_field == 2'b10 && high_timer_interrupt |-> low_timer_interrupt;
  endproperty
  property p_irq_pulse;
    high_timer_interrupt |=> !high_timer_interrupt;
  endproperty
  a_start: assert property (p_start) else $error("unit did not start");
  a_nocas: assert property (p_nocas) else $error("ran without cascade");
  a_stop: assert property (p_stop) else $error("stop did not clear");
  a_idle: assert property (p_idle) else $error("idle pin level wrong");
  a_ppg_duty: assert property (p_ppg_duty) else $error("duty match level wrong");
  a_ppg_per: assert property (p_ppg_per) else $error("period match wrong");
  a_pwm_ovf: assert property (p_pwm_ovf) else $error("overflow wrong");
  a_pwm_frame: assert property (p_pwm_frame) else $error("frame irq alone");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
endmodule // ctp_props

bind ctp_timer_pwm ctp_props u_props (.clk(clk), .sys_rst(sys_rst), .cascade_select(cascade_select),
  .high_timer_run(high_timer_run), .operating_mode_field(operating_mode_field),
  .output_initial_level(output_initial_level), .count_value(count_value), .running(running),
  .dithered_output_pin(dithered_output_pin), .pulse_output_pin(pulse_output_pin),
  .low_timer_interrupt(low_timer_interrupt), .high_timer_interrupt(high_timer_interrupt));

// ===== tb/testbench.sv
// self-checking bench for the cascaded timer unit
// assumes the unit is driven straight through its ports on one clock
`timescale 1ns/100ps
module testbench;
  localparam [31:0] SH = 32'h012468AB;
  localparam [83:0] DT = {12'h200, 12'h10F, 12'h108, 12'h104, 12'h102, 12'h101, 12'h100};
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg cas = 1'b1;
  reg run = 1'b0;
  reg [1:0] mode = 2'b11;
  reg init = 1'b0;
  reg dbe = 1'b0;
  reg ext = 1'b0;
  reg [2:0] div = 3'b111;
  reg slow = 1'b0;
  reg lft = 1'b0;
  reg ecin = 1'b0;
  reg wr = 1'b0;
  reg [1:0] sel = 2'b00;
  reg [7:0] wd = 8'h00;
  wire [15:0] duty_rd, per_rd, cnt;
  wire running, dpin, ppin, lo_irq, hi_irq;
  integer err_count = 0;
  integer checks_done = 0;
  integer n, lo, h, h0, i;
  ctp_timer_pwm dut (.clk(clk), .sys_rst(sys_rst), .cascade_select(cas), .high_timer_run(run),
    .operating_mode_field(mode), .output_initial_level(init), .double_buffer_enable(dbe),
    .external_clock_select(ext), .clock_divider_field(div), .slow_prescale_select(slow),
    .low_frequency_tick(lft), .external_count_input(ecin), .reg_write(wr), .reg_select(sel),
    .reg_write_data(wd), .duty_read_value(duty_rd), .period_read_value(per_rd), .count_value(cnt),
    .running(running), .dithered_output_pin(dpin), .pulse_output_pin(ppin),
    .low_timer_interrupt(lo_irq), .high_timer_interrupt(hi_irq));
  initial
  begin
    forever #20 clk = ~clk;
  end
  // slow tick every 4 cycles, count input 4 cycles high and 4 low
  always
  begin
    repeat (3) @(posedge clk);
    #2 lft = 1'b1;
    @(posedge clk);
    #2 lft = 1'b0;
  end
  always
  begin
    repeat (4) @(posedge clk);
    #2 ecin = ~ecin;
  end
  task tk;
    begin
      @(posedge clk);
      #2;
    end
  endtask
  task chk(input [63:0] name, input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("FAIL %0s expected %0d seen %0d", name, exp, got);
      end
    end
  endtask
  // four byte writes, duty high last
  task wall(input [15:0] p, input [15:0] d);
    integer j;
    begin
      wr = 1'b1;
      for (j = 0; j < 4; j = j + 1)
      begin
        sel = j[1:0];
        wd = (j == 0) ? p[7:0] : (j == 1) ? p[15:8] : (j == 2) ? d[7:0] : d[15:8];
        tk;
      end
      wr = 1'b0;
    end
  endtask
  task start(input [1:0] m, input e, input [2:0] dv, input s, input b, input iv);
    begin
      run = 1'b0;
      tk;
      mode = m;
      ext = e;
      div = dv;
      slow = s;
      dbe = b;
      init = iv;
      tk;
    end
  endtask
  // cycles, low irqs and active pin cycles up to the next high irq
  task per;
    begin
      n = 0;
      lo = 0;
      h = 0;
      while (n < 9000 && (n == 0 || hi_irq !== 1'b1))
      begin
        tk;
        n = n + 1;
        lo = lo + (lo_irq === 1'b1);
        h = h + ((mode[0] ? ppin : dpin) !== init);
      end
    end
  endtask
  task wchg;
    reg [15:0] c;
    begin
      c = cnt;
      n = 0;
      while (cnt === c && n < 5000)
      begin
        tk;
        n = n + 1;
      end
    end
  endtask
  task rate(input e, input [2:0] dv, input s, input [15:0] exp);
    begin
      start(2'b11, e, dv, s, 1'b0, 1'b0);
      run = 1'b1;
      wchg;
      wchg;
      chk("rate", n, exp);
    end
  endtask
  task t_idle;
    begin
      init = 1'b1;
      tk;
      chk("idle_hi", {dpin, ppin}, 2'b11);
      cas = 1'b0;
      run = 1'b1;
      repeat (3) tk;
      chk("nocas", running, 0);
      cas = 1'b1;
      mode = 2'b00;
      repeat (3) tk;
      chk("badmode", running, 0);
      run = 1'b0;
      init = 1'b0;
      tk;
      chk("idle_lo", {dpin, ppin}, 2'b00);
    end
  endtask
  task t_ppg(input b);
    begin
      start(2'b11, 1'b0, 3'b111, 1'b0, b, 1'b0);
      wall(16'd20, 16'd12);
      run = 1'b1;
      per;
      per;
      chk("period", n, 20);
      chk("duty_irq", lo, 1);
      h0 = h;
      fork
        per;
        begin
          repeat (2) tk;
          wall(b ? 16'd30 : 16'd20, b ? 16'd12 : 16'd4);
        end
      join
      chk("old_per", n, 20);
      chk("old_high", h, b ? h0 : 0);
      per;
      chk("new_per", n, b ? 30 : 20);
      chk("new_high", h, h0 + (b ? 10 : 8));
      chk("rd_per", per_rd, b ? 30 : 20);
      run = 1'b0;
      tk;
      chk("stop", cnt, 0);
    end
  endtask
  task t_pwm;
    begin
      start(2'b10, 1'b0, 3'b111, 1'b0, 1'b1, 1'b1);
      wall(16'h0000, 16'hA100);
      run = 1'b1;
      tk;
      // active cycles per frame at duty 16: sixteen periods of 255 - 16
      h0 = 3824;
      for (i = 0; i < 7; i = i + 1)
      begin
        wall(16'h0000, {4'hA, DT[12*i +: 12]});
        chk("duty_rd", duty_rd, {4'hA, DT[12*i +: 12]});
        per;
        per;
        chk("frame", n, 4096);
        chk("ovf", lo, 16);
        chk("active", h, h0 + 256 - DT[12*i +: 12]);
      end
      run = 1'b0;
      tk;
      chk("stop", {cnt, dpin}, 17'h00001);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // watchdog well beyond the expected run length
  initial
  begin
    #4000000;
    err_count = err_count + 1;
    stop_test;
  end
  // reset, then the scenarios in turn
  initial
  begin
    repeat (4) @(posedge clk);
    #2 sys_rst = 1'b0;
    t_idle;
    for (i = 0; i < 8; i = i + 1)
      rate(1'b0, i[2:0], 1'b0, 16'h1 << SH[4*i +: 4]);
    rate(1'b0, 3'b000, 1'b1, 16'd64);
    rate(1'b0, 3'b001, 1'b1, 16'd32);
    rate(1'b1, 3'b111, 1'b0, 16'd8);
    t_ppg(1'b1);
    t_ppg(1'b0);
    t_pwm;
    stop_test;
  end
endmodule // testbench
